// *** inc/cbu_pkg.sv ***
// Overview of operation
// - Carry clear or set selects same-or-higher, lower.
// - Signed greater-or-equal taken when N xor V zero.
// - Signed less-than taken when N xor V one.
// - Half-carry set branch redirects when H one.
// - Half-carry clear branch redirects when H zero.
// - Transfer-set branch taken when T is one.
// - Transfer-clear branch taken when T zero, no flags.
// - Overflow-set branch taken when V is one.
// - Overflow-clear branch taken when V is zero.
// - Interrupt-enabled branch taken when I is one.
// - Interrupt-disabled branch taken when I is zero.
// - Generic set/clear forms test any flag bit; index 4 tests N xor V, not the stored bit.
package cbu_pkg;

    // Conditional branch opcode: top five bits fixed, bit 10 picks set or clear test.
    localparam logic [15:0] CBU_BR_MASK  = 16'hF800;
    localparam logic [15:0] CBU_BR_MATCH = 16'hF000;

    // Field positions inside the instruction word.
    localparam int CBU_POL_BIT = 10;
    localparam int CBU_K_MSB   = 9;
    localparam int CBU_K_LSB   = 3;
    localparam int CBU_K_W     = 7;
    localparam int CBU_S_MSB   = 2;
    localparam int CBU_S_LSB   = 0;

    // Bit indices of the status flags register.
    localparam logic [2:0] CBU_FLAG_C = 3'h0;
    localparam logic [2:0] CBU_FLAG_Z = 3'h1;
    localparam logic [2:0] CBU_FLAG_N = 3'h2;
    localparam logic [2:0] CBU_FLAG_V = 3'h3;
    localparam logic [2:0] CBU_FLAG_S = 3'h4;
    localparam logic [2:0] CBU_FLAG_H = 3'h5;
    localparam logic [2:0] CBU_FLAG_T = 3'h6;
    localparam logic [2:0] CBU_FLAG_I = 3'h7;

    // Default program counter width in bits; the counter addresses words.
    localparam int CBU_PC_W = 12;

    // Cycles from acceptance to completion.
    localparam int CBU_FALL_CYCLES  = 1;
    localparam int CBU_TAKEN_CYCLES = 2;

    // Sequencer states, one-hot.
    typedef enum logic [1:0]
    {
        CBU_ST_IDLE     = 2'h1,
        CBU_ST_REDIRECT = 2'h2
    } cbu_state_e;

endpackage

// *** verilog/cbu_flag_test.sv ***
`timescale 1ns/1ns
module cbu_flag_test
    import cbu_pkg::*;
(
    // Flag snapshot and selection.
    input  wire logic [7:0] flags,
    input  wire logic [2:0] sel,
    input  wire logic       want_clear,
    // Result.
    output logic            hit
);
    // Selected bit value before polarity is applied.
    logic bit_val;

    // The sign bit is rebuilt from N xor V so the signed compare does not depend
    // on the core keeping its stored sign flag coherent.
    always_comb
    begin
        if (sel == CBU_FLAG_S)
        begin
            bit_val = flags[CBU_FLAG_N] ^ flags[CBU_FLAG_V];
        end
        else
        begin
            bit_val = flags[sel];
        end
        // A clear-test branch is taken on a zero bit, a set-test on a one bit.
        hit = bit_val ^ want_clear;
    end

endmodule

// *** verilog/cbu_branch.sv ***
`timescale 1ns/1ns
module cbu_branch
    import cbu_pkg::*;
#(
    parameter int PC_W = cbu_pkg::CBU_PC_W
)
(
    // Clock and reset.
    input  wire logic            CLK,
    input  wire logic            SYS_RST,
    // Instruction offered by the fetch stage.
    input  wire logic            INSN_VALID,
    input  wire logic [15:0]     INSN,
    input  wire logic [PC_W-1:0] PC_CUR,
    // Status flags from the core.
    input  wire logic [7:0]      STATUS_FLAGS,
    // Answer to the program counter logic.
    output logic                 BUSY,
    output logic                 DONE,
    output logic                 PC_LOAD,
    output logic                 BR_TAKEN,
    output logic [PC_W-1:0]      PC_NEXT
);
    import cbu_pkg::*;

    // Current sequencer state.
    cbu_state_e      state;
    // Branch target held across the extra cycle of a taken branch.
    logic [PC_W-1:0] target;
    // Decoded fields of the offered instruction.
    logic            is_br;
    logic [2:0]      sel;
    logic            want_clear;
    logic [CBU_K_W-1:0] k;
    // Result of the flag test.
    logic            hit;
    // Candidate next program counters.
    logic [PC_W-1:0] next_target;
    logic [PC_W-1:0] next_fall;

    // Decode. An instruction offered while a redirect is pending is ignored,
    // since the core is told to stall by BUSY in that cycle.
    always_comb
    begin
        is_br      = INSN_VALID && ((INSN & CBU_BR_MASK) == CBU_BR_MATCH) && (state == CBU_ST_IDLE);
        sel        = INSN[CBU_S_MSB:CBU_S_LSB];
        want_clear = INSN[CBU_POL_BIT];
        k          = INSN[CBU_K_MSB:CBU_K_LSB];
    end

    // The flag test is one shared comparator for every condition; the named
    // branches are only particular bit and polarity choices of the generic form.
    cbu_flag_test u_flag_test
    (
        .flags      (STATUS_FLAGS),
        .sel        (sel),
        .want_clear (want_clear),
        .hit        (hit)
    );

    // Target arithmetic. The offset is sign extended so branches reach
    // backward as well as forward; the sum wraps at the program counter width.
    always_comb
    begin
        next_target = PC_CUR + {{(PC_W-CBU_K_W){k[CBU_K_W-1]}}, k} + PC_W'(1);
        next_fall   = PC_CUR + PC_W'(1);
    end

    // Sequencer. A taken branch spends one extra cycle in the redirect state,
    // which is the cost of the pipeline refill it causes.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state <= CBU_ST_IDLE;
        end
        else
        begin
            case (state)
                CBU_ST_IDLE:
                begin
                    // Only a satisfied condition leaves idle.
                    if (is_br && hit)
                    begin
                        state <= CBU_ST_REDIRECT;
                    end
                end
                CBU_ST_REDIRECT:
                begin
                    // The redirect always completes in one cycle.
                    state <= CBU_ST_IDLE;
                end
                default:
                begin
                    // Recover from an illegal code.
                    state <= CBU_ST_IDLE;
                end
            endcase
        end
    end

    // Target capture, so the core may change PC_CUR during the extra cycle.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            target <= '0;
        end
        else if (is_br && hit)
        begin
            target <= next_target;
        end
    end

    // Stall request: high during the extra cycle of a taken branch.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            BUSY <= 1'b0;
        end
        else
        begin
            BUSY <= is_br && hit;
        end
    end

    // Completion pulse: one cycle after a fall-through, two after a taken branch.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            DONE <= 1'b0;
        end
        else
        begin
            DONE <= (is_br && !hit) || (state == CBU_ST_REDIRECT);
        end
    end

    // Load strobe and taken indication, both only at the end of a redirect.
    // No flag output exists at all, so the status register is never altered.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PC_LOAD  <= 1'b0;
            BR_TAKEN <= 1'b0;
        end
        else
        begin
            PC_LOAD  <= (state == CBU_ST_REDIRECT);
            BR_TAKEN <= (state == CBU_ST_REDIRECT);
        end
    end

    // Next program counter: incremented value on fall-through, target on redirect.
    // It holds its last value otherwise, so it is only meaningful with DONE.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PC_NEXT <= '0;
        end
        else if (state == CBU_ST_REDIRECT)
        begin
            PC_NEXT <= target;
        end
        else if (is_br && !hit)
        begin
            PC_NEXT <= next_fall;
        end
    end

    // A taken branch: stall cycle, then the load of the captured target.
    sequence s_redirect;
        ##1 (BUSY && !DONE) ##1 (DONE && PC_LOAD && BR_TAKEN && !BUSY && PC_NEXT == $past(next_target, 2));
    endsequence

    // A branch not taken: completes next cycle with no load.
    sequence s_fall;
        ##1 (DONE && !PC_LOAD && !BUSY && PC_NEXT == $past(next_fall, 1));
    endsequence

    // Condition satisfied must redirect in exactly two cycles.
    property p_taken(logic cond);
        @(posedge CLK) disable iff (SYS_RST)
        (is_br && cond) |-> s_redirect;
    endproperty

    // Condition unsatisfied must fall through in exactly one cycle.
    property p_not_taken(logic cond);
        @(posedge CLK) disable iff (SYS_RST)
        (is_br && cond) |-> s_fall;
    endproperty

    AST_LOWER_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_C && !want_clear && STATUS_FLAGS[CBU_FLAG_C]))
        else $error("Lower branch with carry set did not redirect.");

    AST_SAME_HIGHER_FALLS:
        assert property (p_not_taken(sel == CBU_FLAG_C && want_clear && STATUS_FLAGS[CBU_FLAG_C]))
        else $error("Same-or-higher branch with carry set did not fall through.");

    AST_SIGNED_GE_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_S && want_clear
                                 && !(STATUS_FLAGS[CBU_FLAG_N] ^ STATUS_FLAGS[CBU_FLAG_V])))
        else $error("Signed greater-or-equal branch did not redirect.");

    AST_SIGNED_LT_FALLS:
        assert property (p_not_taken(sel == CBU_FLAG_S && !want_clear
                                     && !(STATUS_FLAGS[CBU_FLAG_N] ^ STATUS_FLAGS[CBU_FLAG_V])))
        else $error("Signed less-than branch was taken with N equal to V.");

    AST_HALF_SET_FALLS:
        assert property (p_not_taken(sel == CBU_FLAG_H && !want_clear && !STATUS_FLAGS[CBU_FLAG_H]))
        else $error("Half-carry set branch was taken with H clear.");

    AST_HALF_CLEAR_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_H && want_clear && !STATUS_FLAGS[CBU_FLAG_H]))
        else $error("Half-carry clear branch did not redirect.");

    AST_TRANSFER_SET_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_T && !want_clear && STATUS_FLAGS[CBU_FLAG_T]))
        else $error("Transfer set branch did not redirect.");

    AST_TRANSFER_CLEAR_FALLS:
        assert property (p_not_taken(sel == CBU_FLAG_T && want_clear && STATUS_FLAGS[CBU_FLAG_T]))
        else $error("Transfer clear branch was taken with T set.");

    AST_OVERFLOW_SET_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_V && !want_clear && STATUS_FLAGS[CBU_FLAG_V]))
        else $error("Overflow set branch did not redirect.");

    AST_OVERFLOW_CLEAR_FALLS:
        assert property (p_not_taken(sel == CBU_FLAG_V && want_clear && STATUS_FLAGS[CBU_FLAG_V]))
        else $error("Overflow clear branch was taken with V set.");

    AST_IRQ_ENABLED_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_I && !want_clear && STATUS_FLAGS[CBU_FLAG_I]))
        else $error("Interrupt enabled branch did not redirect.");

    AST_IRQ_DISABLED_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_I && want_clear && !STATUS_FLAGS[CBU_FLAG_I]))
        else $error("Interrupt disabled branch did not redirect.");

    AST_ZERO_CLEAR_FALLS:
        assert property (p_not_taken(sel == CBU_FLAG_Z && want_clear && STATUS_FLAGS[CBU_FLAG_Z]))
        else $error("Not-equal branch was taken with Z set.");

    AST_NEGATIVE_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_N && !want_clear && STATUS_FLAGS[CBU_FLAG_N]))
        else $error("Negative branch did not take two cycles.");

    // Each flag index is checked in both outcomes, so a swapped polarity cannot hide.
    AST_SAME_HIGHER_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_C && want_clear && !STATUS_FLAGS[CBU_FLAG_C]))
        else $error("Same-or-higher branch with carry clear did not redirect.");

    AST_SIGNED_GE_FALLS:
        assert property (p_not_taken(sel == CBU_FLAG_S && want_clear
                                     && (STATUS_FLAGS[CBU_FLAG_N] ^ STATUS_FLAGS[CBU_FLAG_V])))
        else $error("Signed greater-or-equal branch was taken with N differing from V.");

    AST_SIGNED_LT_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_S && !want_clear
                                 && (STATUS_FLAGS[CBU_FLAG_N] ^ STATUS_FLAGS[CBU_FLAG_V])))
        else $error("Signed less-than branch did not redirect.");

    AST_HALF_SET_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_H && !want_clear && STATUS_FLAGS[CBU_FLAG_H]))
        else $error("Half-carry set branch did not redirect.");

    AST_TRANSFER_CLEAR_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_T && want_clear && !STATUS_FLAGS[CBU_FLAG_T]))
        else $error("Transfer clear branch did not redirect.");

    AST_OVERFLOW_CLEAR_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_V && want_clear && !STATUS_FLAGS[CBU_FLAG_V]))
        else $error("Overflow clear branch did not redirect.");

    AST_IRQ_ENABLED_FALLS:
        assert property (p_not_taken(sel == CBU_FLAG_I && !want_clear && !STATUS_FLAGS[CBU_FLAG_I]))
        else $error("Interrupt enabled branch was taken with I clear.");

    AST_ZERO_SET_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_Z && !want_clear && STATUS_FLAGS[CBU_FLAG_Z]))
        else $error("Equal branch did not redirect.");

    AST_POSITIVE_TAKEN:
        assert property (p_taken(sel == CBU_FLAG_N && want_clear && !STATUS_FLAGS[CBU_FLAG_N]))
        else $error("Positive branch did not take two cycles.");

    AST_NEGATIVE_FALLS:
        assert property (p_not_taken(sel == CBU_FLAG_N && !want_clear && !STATUS_FLAGS[CBU_FLAG_N]))
        else $error("Negative branch was taken with N clear.");

    // The stall cycle refuses any new branch, so two stalls never run back to back.
    AST_STALL_REFUSES:
        assert property (@(posedge CLK) disable iff (SYS_RST)
                         BUSY |=> !BUSY)
        else $error("A branch was accepted during the stall cycle.");

    // An offset of minus one must land back on the branch itself.
    AST_BACKWARD_OFFSET:
        assert property (@(posedge CLK) disable iff (SYS_RST)
                         (is_br && hit && k == 7'h7F) |-> ##2 (PC_LOAD && PC_NEXT == $past(PC_CUR, 2)))
        else $error("Backward offset gave a wrong target.");

    // Stall and completion never overlap, and a load never comes without DONE.
    AST_LOAD_NEEDS_DONE:
        assert property (@(posedge CLK) disable iff (SYS_RST)
                         PC_LOAD |-> (DONE && !BUSY && $past(BUSY)))
        else $error("Load strobe without a completed redirect.");

endmodule

// *** tb/cbu_core_model.sv ***
`timescale 1ns/1ns
// Stand-in for the core's program counter logic on the far side of the branch unit.
module cbu_core_model
#(
    parameter int PC_W = 12
)
(
    // Clock and reset.
    input  wire logic            CLK,
    input  wire logic            SYS_RST,
    // Answer from the branch unit.
    input  wire logic            DONE,
    input  wire logic [PC_W-1:0] PC_NEXT,
    // Preset from the bench, used to place code near either end of memory.
    input  wire logic            PRESET,
    input  wire logic [PC_W-1:0] PRESET_PC,
    // Address of the instruction now offered.
    output logic      [PC_W-1:0] PC
);
    // Apart from reset and preset, the counter moves only on a completed branch; it never guesses ahead of the unit.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PC <= '0;
        end
        else if (PRESET)
        begin
            PC <= PRESET_PC;
        end
        else if (DONE)
        begin
            PC <= PC_NEXT;
        end
    end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ns
// Self-checking bench for the conditional branch unit.
module testbench;
    import cbu_pkg::*;
    logic        clk = 1'b0;      // Core clock, 50 ns period.
    logic        sys_rst = 1'b1;  // Synchronous reset.
    logic        insn_valid = 1'b0;
    logic [15:0] insn = 16'h0000;
    logic [7:0]  status_flags = 8'h00;
    logic        preset = 1'b0;
    logic [11:0] preset_pc = 12'h000;
    logic [11:0] pc_cur;          // Driven by the core model.
    logic [11:0] cur_pc = 12'h000; // Bench's own idea of the program counter.
    logic        busy, done, pc_load, br_taken;
    logic [11:0] pc_next;
    int          mismatches = 0;
    int          cmp_count = 0;

    always #25 clk = ~clk;

    cbu_branch #(.PC_W(12)) u_cbu_branch (.CLK(clk), .SYS_RST(sys_rst), .INSN_VALID(insn_valid), .INSN(insn),
        .PC_CUR(pc_cur), .STATUS_FLAGS(status_flags), .BUSY(busy), .DONE(done), .PC_LOAD(pc_load),
        .BR_TAKEN(br_taken), .PC_NEXT(pc_next));
    cbu_core_model #(.PC_W(12)) u_cbu_core_model (.CLK(clk), .SYS_RST(sys_rst), .DONE(done), .PC_NEXT(pc_next),
        .PRESET(preset), .PRESET_PC(preset_pc), .PC(pc_cur));

    // Compare one value and report a mismatch at once.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic close_out();
        $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Move both program counters to a chosen address.
    task automatic set_pc(input logic [11:0] v);
        @(posedge clk);
        preset <= 1'b1;
        preset_pc <= v;
        @(posedge clk);
        preset <= 1'b0;
        cur_pc = v;
    endtask

    // Offer one branch for a single cycle and judge its timing and target.
    task automatic branch(input logic pol, input logic [2:0] s, input logic [6:0] k, input logic [7:0] fl,
                          input logic tk);
        logic [11:0] exp;
        int          n;
        exp = tk ? cur_pc + {{5{k[6]}}, k} + 12'h001 : cur_pc + 12'h001;
        @(posedge clk);
        insn_valid <= 1'b1;
        insn <= {5'h1E, pol, k, s};
        status_flags <= fl;
        @(posedge clk);
        insn_valid <= 1'b0;
        #1;
        chk("busy", {15'h0000, tk}, {15'h0000, busy});
        n = 1;
        while (done !== 1'b1 && n < 5)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("cycles", tk ? 16'h0002 : 16'h0001, 16'(n));
        chk("taken", {15'h0000, tk}, {15'h0000, br_taken});
        chk("load", {15'h0000, tk}, {15'h0000, pc_load});
        chk("next", {4'h0, exp}, {4'h0, pc_next});
        cur_pc = exp;
    endtask

    // Every flag index, both polarities, condition true and false; index 4 is sign = N xor V.
    task automatic sweep_flags();
        logic [7:0] fl;
        for (int s = 0; s < 8; s++)
            for (int p = 0; p < 2; p++)
                for (int v = 0; v < 2; v++)
                begin
                    if (s == 4)
                        fl = (v == 1) ? 8'h04 : 8'h1C;
                    else
                        fl = (v == 1) ? (8'h01 << s) : ~(8'h01 << s);
                    branch(p[0], 3'(s), (v == 1) ? 7'h7D : 7'h11, fl, v[0] ^ p[0]);
                end
    endtask

    // Offsets that wrap past either end of program memory.
    task automatic wrap_offsets();
        set_pc(12'hFFE);
        branch(1'b0, CBU_FLAG_Z, 7'h03, 8'h02, 1'b1);
        set_pc(12'h001);
        branch(1'b1, CBU_FLAG_C, 7'h40, 8'h00, 1'b1);
        branch(1'b0, CBU_FLAG_N, 7'h7F, 8'h04, 1'b1);
    endtask

    // Reset in the stall cycle of a taken branch must cancel the load; the unit then works again.
    task automatic reset_mid();
        @(posedge clk);
        insn_valid <= 1'b1;
        insn <= {5'h1E, 1'b0, 7'h09, CBU_FLAG_T};
        status_flags <= 8'h40;
        @(posedge clk);
        insn_valid <= 1'b0;
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("mid reset", 16'h0000, {busy, done, pc_load, br_taken, pc_next});
        cur_pc = 12'h000;
        branch(1'b0, CBU_FLAG_T, 7'h09, 8'h40, 1'b1);
    endtask

    // A second branch offered in the stall cycle must be dropped.
    task automatic offer_in_stall();
        int extra;
        @(posedge clk);
        insn_valid <= 1'b1;
        insn <= {5'h1E, 1'b0, 7'h05, CBU_FLAG_I};
        status_flags <= 8'h80;
        @(posedge clk);
        @(posedge clk);
        insn_valid <= 1'b0;
        #1;
        chk("stall done", 16'h0001, {15'h0000, done});
        chk("stall next", {4'h0, cur_pc + 12'h006}, {4'h0, pc_next});
        cur_pc = cur_pc + 12'h006;
        extra = 0;
        repeat (3)
        begin
            @(posedge clk);
            #1;
            extra += (done !== 1'b0 || busy !== 1'b0) ? 1 : 0;
        end
        chk("stall extra", 16'h0000, 16'(extra));
    endtask

    // Words outside the branch pattern give no answer at all.
    task automatic non_branch();
        int seen;
        seen = 0;
        @(posedge clk);
        insn_valid <= 1'b1;
        insn <= 16'hF800;
        @(posedge clk);
        insn <= 16'h0000;
        repeat (4)
        begin
            #1;
            seen += (done !== 1'b0 || busy !== 1'b0 || pc_load !== 1'b0) ? 1 : 0;
            @(posedge clk);
            insn_valid <= 1'b0;
        end
        chk("ignored", 16'h0000, 16'(seen));
    endtask

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("reset outs", 16'h0000, {busy, done, pc_load, br_taken, pc_next});
        sweep_flags();
        wrap_offsets();
        offer_in_stall();
        non_branch();
        reset_mid();
        close_out();
    end

    // Watchdog: the tests need about 120 cycles; far longer means a hang.
    initial
    begin
        #(5000 * 50);
        mismatches++;
        close_out();
    end
endmodule
